// *** logic/exc_pkg.sv ***
// Contract
// - fifteen exception numbers 1..15; 4, 7-10 and 13 are reserved.
// - reset, nmi, hard fault have fixed priorities -3, -2, -1.
// - a fault whose handler is disabled escalates to hard fault, number 3.
// - bus fault, number 5, raised on a slave error response on fetch or data.
// - usage fault, number 6, raised on program errors.
// - debug monitor, number 12, raised on watchpoint, breakpoint, external debug request.
// - service call 11, pendable request 14, system tick 15 have programmable priorities.
// - each programmable exception is individually enabled; enabled ones dispatch like interrupts.
// - assertions are detected and held pending while masked.
// - enabled but masked pending requests are not dispatched until unmasked.
// - global priority mask blocks everything except reset, nmi and hard fault.
// - fault mask blocks everything except reset and nmi.
// - a non-zero base threshold masks programmable requests with priority number at or below it.
// - sleep and hibernate wakeup sources bypass the edge detector.
// - core runs with controller clock gated only in active and alternate-active modes.
package exc_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] ADDR_ENABLE    = 4'h0;
  localparam logic [3:0] ADDR_PENDING   = 4'h1;
  localparam logic [3:0] ADDR_PRIO_LO   = 4'h2;
  localparam logic [3:0] ADDR_PRIO_HI   = 4'h3;
  localparam logic [3:0] ADDR_MASKS     = 4'h4;
  localparam logic [3:0] ADDR_DISPATCH  = 4'h5;
  localparam logic [3:0] ADDR_PEND_SET  = 4'h6;
  localparam logic [3:0] ADDR_PEND_CLR  = 4'h7;
  localparam logic [3:0] ADDR_CTRL      = 4'h8;
  // ==========================================================
  // exception numbers and field layout
  localparam int NUM_EXC      = 16;
  localparam int PRIO_W       = 8;
  localparam logic [15:0] IMPL_MASK  = 16'hd86e;
  localparam logic [15:0] PROG_MASK  = 16'hd860;
  localparam logic [15:0] FAULT_MASK_BITS = 16'h0060;
  localparam logic [3:0] EXC_RESET   = 4'h1;
  localparam logic [3:0] EXC_NMI     = 4'h2;
  localparam logic [3:0] EXC_HARD    = 4'h3;
  localparam logic [3:0] EXC_BUS     = 4'h5;
  localparam logic [3:0] EXC_USAGE   = 4'h6;
  localparam logic [3:0] EXC_SVC     = 4'hb;
  localparam logic [3:0] EXC_DEBUG   = 4'hc;
  localparam logic [3:0] EXC_PENDSYS = 4'he;
  localparam logic [3:0] EXC_TICK    = 4'hf;
  // fixed priorities, signed, below any programmable value
  localparam logic signed [9:0] PRI_RESET = -10'sd3;
  localparam logic signed [9:0] PRI_NMI   = -10'sd2;
  localparam logic signed [9:0] PRI_HARD  = -10'sd1;
  localparam logic signed [9:0] PRI_NONE  = 10'sh1ff;
  // ==========================================================
  // reset values
  localparam logic [15:0] RST_ENABLE = 16'h000e;
  localparam logic [7:0]  RST_PRIO   = 8'h00;
  localparam logic [7:0]  RST_BASE   = 8'h00;
endpackage

// *** logic/exc_source_front.sv ***
`timescale 1ns/10ps
module exc_source_front (
  // clock and reset
  input  wire logic  mclk_i,
  input  wire logic  rst_n_i,
  // selection per line: 1 = direct level path, 0 = edge path
  input  wire logic [15:0] direct_sel_i,
  // source side
  exc_src_if.front   src
);
  logic [15:0] sync_a;
  logic [15:0] sync_b;
  logic [15:0] prev;

  // ==========================================================
  // two-stage synchroniser, only sync_b is read
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= 16'h0000;
      sync_b <= 16'h0000;
    end else begin
      sync_a <= src.raw;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev <= 16'h0000;
    end else begin
      prev <= sync_b;
    end
  end

  // wakeup lines skip the edge detector so a held level still wakes the core
  assign src.pend_set = (direct_sel_i & sync_b) | (~direct_sel_i & sync_b & ~prev);
endmodule

// *** logic/exc_src_if.sv ***
`timescale 1ns/10ps
interface exc_src_if;
  logic [15:0] raw;
  logic [15:0] pend_set;
  modport front (input raw, output pend_set);
  modport core  (input pend_set);
endinterface

// *** logic/exception_mask_power_ctrl.sv ***
`timescale 1ns/10ps
module exception_mask_power_ctrl (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // exception sources (from outside the clock domain)
  input  wire logic        sys_reset_req_i,
  input  wire logic        nmi_i,
  input  wire logic        bus_err_fetch_i,
  input  wire logic        bus_err_data_i,
  input  wire logic        usage_err_i,
  input  wire logic        svc_req_i,
  input  wire logic        watchpoint_i,
  input  wire logic        breakpoint_i,
  input  wire logic        ext_debug_req_i,
  input  wire logic        tick_i,
  // core side
  input  wire logic        ack_i,
  output logic             req_o,
  output logic      [3:0]  vec_o,
  // power mode status for polling
  input  wire logic [1:0]  power_mode_i,
  output logic      [1:0]  power_mode_status_o
);
  // ==========================================================
  // state
  logic [15:0] enable;
  logic [15:0] pending;
  logic [7:0]  prio [exc_pkg::NUM_EXC];
  logic        global_priority_mask;
  logic        fault_mask_a;
  logic [7:0]  base_priority_threshold;
  logic [15:0] direct_sel;
  logic [1:0]  pm_a;
  logic [15:0] raw;
  logic [15:0] next_set;
  logic [15:0] eligible;
  logic [3:0]  next_vec;
  logic        next_found;
  logic signed [9:0] best_pri;
  logic signed [9:0] cur_pri;

  exc_src_if src ();

  // ==========================================================
  // source lines onto exception numbers
  always_comb begin
    raw = 16'h0000;
    raw[exc_pkg::EXC_RESET] = sys_reset_req_i;
    raw[exc_pkg::EXC_NMI]   = nmi_i;
    raw[exc_pkg::EXC_BUS]   = bus_err_fetch_i | bus_err_data_i;
    raw[exc_pkg::EXC_USAGE] = usage_err_i;
    raw[exc_pkg::EXC_SVC]   = svc_req_i;
    raw[exc_pkg::EXC_DEBUG] = watchpoint_i | breakpoint_i | ext_debug_req_i;
    raw[exc_pkg::EXC_TICK]  = tick_i;
  end
  assign src.raw = raw;

  exc_source_front u_front (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .direct_sel_i (direct_sel),
    .src          (src.front)
  );

  // ==========================================================
  // fault routing: disabled fault handler escalates to hard fault
  always_comb begin
    next_set = src.pend_set & exc_pkg::IMPL_MASK;
    if (wr_i && addr_i == exc_pkg::ADDR_PEND_SET) begin
      next_set = next_set | (wdata_i[15:0] & exc_pkg::IMPL_MASK);
    end
    if (|(next_set & exc_pkg::FAULT_MASK_BITS & ~enable)) begin
      next_set[exc_pkg::EXC_HARD] = 1'b1;
    end
    next_set = next_set & ~(exc_pkg::FAULT_MASK_BITS & ~enable);
  end

  // ==========================================================
  // pending bits, set wins over clear and over masking
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending <= 16'h0000;
    end else begin
      logic [15:0] clr;
      clr = 16'h0000;
      if (wr_i && addr_i == exc_pkg::ADDR_PEND_CLR) begin
        clr = wdata_i[15:0];
      end
      if (ack_i && req_o) begin
        clr[vec_o] = 1'b1;
      end
      pending <= (pending & ~clr) | next_set;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable <= exc_pkg::RST_ENABLE;
    end else if (wr_i && addr_i == exc_pkg::ADDR_ENABLE) begin
      // reset, nmi and hard fault cannot be turned off
      enable <= (wdata_i[15:0] & exc_pkg::PROG_MASK) | exc_pkg::RST_ENABLE;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < exc_pkg::NUM_EXC; i++) begin
        prio[i] <= exc_pkg::RST_PRIO;
      end
    end else if (wr_i && (addr_i == exc_pkg::ADDR_PRIO_LO || addr_i == exc_pkg::ADDR_PRIO_HI)) begin
      for (int i = 0; i < 8; i++) begin
        logic [3:0] n;
        n = (addr_i == exc_pkg::ADDR_PRIO_HI) ? 4'(i + 8) : 4'(i);
        if (exc_pkg::PROG_MASK[n]) begin
          prio[n] <= {4'h0, wdata_i[4*i +: 4]};
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      global_priority_mask    <= 1'b0;
      fault_mask_a            <= 1'b0;
      base_priority_threshold <= exc_pkg::RST_BASE;
    end else if (wr_i && addr_i == exc_pkg::ADDR_MASKS) begin
      global_priority_mask    <= wdata_i[0];
      fault_mask_a            <= wdata_i[1];
      base_priority_threshold <= wdata_i[15:8];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      direct_sel <= 16'h0000;
    end else if (wr_i && addr_i == exc_pkg::ADDR_CTRL) begin
      direct_sel <= wdata_i[15:0];
    end
  end

  // ==========================================================
  // masking and arbitration
  function automatic logic signed [9:0] pri_of(input logic [3:0] n, input logic [7:0] p);
    case (n)
      exc_pkg::EXC_RESET: pri_of = exc_pkg::PRI_RESET;
      exc_pkg::EXC_NMI:   pri_of = exc_pkg::PRI_NMI;
      exc_pkg::EXC_HARD:  pri_of = exc_pkg::PRI_HARD;
      default:            pri_of = $signed({2'b00, p});
    endcase
  endfunction

  always_comb begin
    for (int i = 0; i < exc_pkg::NUM_EXC; i++) begin
      logic [3:0] n;
      logic       blocked;
      n = 4'(i);
      blocked = 1'b0;
      if (exc_pkg::PROG_MASK[n]) begin
        if (global_priority_mask) begin
          blocked = 1'b1;
        end
        if (base_priority_threshold != 8'h00 && prio[i] <= base_priority_threshold) begin
          blocked = 1'b1;
        end
      end
      if (fault_mask_a && n != exc_pkg::EXC_NMI && n != exc_pkg::EXC_RESET) begin
        blocked = 1'b1;
      end
      eligible[i] = pending[i] & enable[i] & exc_pkg::IMPL_MASK[i] & ~blocked;
    end
  end

  always_comb begin
    next_vec   = 4'h0;
    next_found = 1'b0;
    best_pri   = exc_pkg::PRI_NONE;
    cur_pri    = exc_pkg::PRI_NONE;
    for (int i = 1; i < exc_pkg::NUM_EXC; i++) begin
      cur_pri = pri_of(4'(i), prio[i]);
      // strict less-than keeps the lower number on a tie
      if (eligible[i] && cur_pri < best_pri) begin
        best_pri   = cur_pri;
        next_vec   = 4'(i);
        next_found = 1'b1;
      end
    end
  end

  // ==========================================================
  // dispatch to core: request and vector follow arbitration each cycle, request dropped after acknowledge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_o <= 1'b0;
      vec_o <= 4'h0;
    end else if (ack_i && req_o) begin
      req_o <= 1'b0;
    end else begin
      req_o <= next_found;
      vec_o <= next_vec;
    end
  end

  // ==========================================================
  // power mode status, polled by software while controller is gated
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pm_a                <= 2'h0;
      power_mode_status_o <= 2'h0;
    end else begin
      pm_a                <= power_mode_i;
      power_mode_status_o <= pm_a;
    end
  end

  // ==========================================================
  // register read, one cycle later
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      case (addr_i)
        exc_pkg::ADDR_ENABLE:   rdata_o <= {16'h0000, enable};
        exc_pkg::ADDR_PENDING:  rdata_o <= {16'h0000, pending};
        exc_pkg::ADDR_PRIO_LO:  rdata_o <= {prio[7][3:0], prio[6][3:0], prio[5][3:0],
                                            prio[4][3:0], prio[3][3:0], prio[2][3:0],
                                            prio[1][3:0], prio[0][3:0]};
        exc_pkg::ADDR_PRIO_HI:  rdata_o <= {prio[15][3:0], prio[14][3:0], prio[13][3:0],
                                            prio[12][3:0], prio[11][3:0], prio[10][3:0],
                                            prio[9][3:0], prio[8][3:0]};
        exc_pkg::ADDR_MASKS:    rdata_o <= {16'h0000, base_priority_threshold, 6'h00,
                                            fault_mask_a, global_priority_mask};
        exc_pkg::ADDR_DISPATCH: rdata_o <= {27'h0000000, req_o, vec_o};
        exc_pkg::ADDR_CTRL:     rdata_o <= {14'h0000, power_mode_status_o, direct_sel};
        default:                rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule

// *** test/core_model.sv ***
`timescale 1ns/10ps
module core_model (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // controller side
  input  wire logic       req_i,
  input  wire logic [1:0] delay_i,
  output logic            ack_o
);
  // ====
  // acknowledge after delay_i waiting cycles
  logic [1:0] wait_q;
  // gating order is played by the bench on the register port
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o  <= 1'b0;
      wait_q <= 2'h0;
    end else if (ack_o || !req_i) begin
      ack_o  <= 1'b0;
      wait_q <= 2'h0;
    end else if (wait_q >= delay_i) begin
      ack_o <= 1'b1;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule

// *** test/exc_mask_assertions.sv ***
`timescale 1ns/10ps
module exc_mask_assertions (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  // register port
  input wire logic [3:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // sources, core side, power mode
  input wire logic        sys_reset_req_i,
  input wire logic        ack_i,
  input wire logic        req_o,
  input wire logic [3:0]  vec_o,
  input wire logic [1:0]  power_mode_i,
  input wire logic [1:0]  power_mode_status_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ====
  // mask shadow; synchroniser needs a few edges after reset
  logic       gm;
  logic       fm;
  logic [2:0] up;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gm <= 1'b0;
      fm <= 1'b0;
    end else if (wr_i && addr_i == exc_pkg::ADDR_MASKS) begin
      gm <= wdata_i[0];
      fm <= wdata_i[1];
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  sequence taken_s;
    req_o && ack_i;
  endsequence
  sequence rst_rise_s;
    !sys_reset_req_i ##1 (sys_reset_req_i && !ack_i)[*5];
  endsequence
  // ====
  // properties
  AST_NO_RESERVED: assert property (req_o |-> exc_pkg::IMPL_MASK[vec_o])
    else $error("reserved vector requested");
  AST_ACK_CLEARS: assert property (taken_s |=> !req_o)
    else $error("request stays after acknowledge");
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read cycle");
  AST_ENABLE_FIXED: assert property (rd_i && addr_i == exc_pkg::ADDR_ENABLE |=>
    rdata_o[3:0] == 4'he && (rdata_o[31:16] == 16'h0)) else $error("enable bits wrong");
  AST_GLOBAL_MASK: assert property (gm && $past(gm) && req_o |-> vec_o <= 4'h3)
    else $error("global mask let a request through");
  AST_FAULT_MASK: assert property (fm && $past(fm) && req_o |-> vec_o <= 4'h2)
    else $error("fault mask let a request through");
  AST_RESET_FIRST: assert property (rst_rise_s |-> ##[0:1] (req_o && vec_o == 4'h1))
    else $error("reset exception not first");
  AST_MODE_SYNC: assert property ((up == 3'h7 && $stable(power_mode_i))[*3] |->
    power_mode_status_o == power_mode_i) else $error("power mode status stale");
endmodule

// *** test/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  // ====
  // signals
  logic        mclk_i, rst_n_i, wr_i, rd_i, ack_i, req_o, free_run, rd_d;
  logic [3:0]  addr_i, vec_o;
  logic [31:0] wdata_i, rdata_o;
  logic [9:0]  src;
  logic [1:0]  power_mode_i, power_mode_status_o, dly;
  int          n_free, num_errors, checks;
  logic [31:0] rd_q[$];
  logic [3:0]  vec_q[$];
  logic [3:0]  src_vec [10] = '{4'h1, 4'h2, 4'h5, 4'h5, 4'h6, 4'hb, 4'hc, 4'hc, 4'hc, 4'hf};
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  exception_mask_power_ctrl uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sys_reset_req_i(src[0]), .nmi_i(src[1]), .bus_err_fetch_i(src[2]),
    .bus_err_data_i(src[3]), .usage_err_i(src[4]), .svc_req_i(src[5]),
    .watchpoint_i(src[6]), .breakpoint_i(src[7]), .ext_debug_req_i(src[8]),
    .tick_i(src[9]), .ack_i(ack_i), .req_o(req_o), .vec_o(vec_o),
    .power_mode_i(power_mode_i), .power_mode_status_o(power_mode_status_o));
  core_model core (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req_o), .delay_i(dly),
    .ack_o(ack_i));
  // ====
  // tasks
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
  endtask
  task automatic fire(input int i, input int n);
    @(posedge mclk_i);
    src <= src | (10'h001 << i);
    repeat (n) @(posedge mclk_i);
    src <= src & ~(10'h001 << i);
  endtask
  task automatic drain;
    int n;
    n = 0;
    dly <= 2'($urandom);
    while (vec_q.size() + rd_q.size() != 0) begin
      @(posedge mclk_i);
      n++;
      if (n > 400) begin
        chk(1'b0, "timeout");
        test_done;
      end
    end
    repeat (6) @(posedge mclk_i);
  endtask
  // ====
  // result watcher: reads one cycle late, dispatches at acknowledge
  always @(posedge mclk_i) begin
    if (rd_d) chk(rdata_o === rd_q.pop_front(), "read data");
    rd_d = rd_i;
    if (req_o === 1'b1 && ack_i === 1'b1) begin
      if (vec_q.size() != 0) chk(vec_o === vec_q.pop_front(), "dispatch vector");
      else if (free_run) n_free++;
      else chk(1'b0, "unexpected dispatch");
    end
  end
  // ====
  // main sequence
  initial begin
    logic [63:0] pw;
    logic [15:0] left;
    int          best;
    void'($urandom(32'hc00cd14f));
    {rst_n_i, wr_i, rd_i, free_run, rd_d, addr_i, wdata_i, src, power_mode_i, dly} = '0;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(exc_pkg::ADDR_ENABLE, 32'h0000000e);
    rd(exc_pkg::ADDR_MASKS, 32'h0);
    rd(4'h9, 32'h0);
    wr(exc_pkg::ADDR_ENABLE, 32'hffffffff);
    rd(exc_pkg::ADDR_ENABLE, 32'h0000d86e);
    pw = {$urandom, $urandom};
    wr(exc_pkg::ADDR_PRIO_LO, pw[31:0]);
    wr(exc_pkg::ADDR_PRIO_HI, pw[63:32]);
    rd(exc_pkg::ADDR_PRIO_LO, pw[31:0] & 32'h0ff00000);
    rd(exc_pkg::ADDR_PRIO_HI, pw[63:32] & 32'hff0ff000);
    left = exc_pkg::PROG_MASK;
    while (left != 16'h0) begin
      best = 0;
      for (int k = 15; k > 0; k--)
        if (left[k] && (best == 0 || pw[4*k +: 4] <= pw[4*best +: 4])) best = k;
      vec_q.push_back(4'(best));
      left[best] = 1'b0;
    end
    wr(exc_pkg::ADDR_PEND_SET, {16'h0, exc_pkg::PROG_MASK});
    drain;
    wr(exc_pkg::ADDR_PRIO_LO, 32'h00300000);
    wr(exc_pkg::ADDR_MASKS, 32'h1);
    wr(exc_pkg::ADDR_PEND_SET, 32'h20);
    repeat (10) @(posedge mclk_i);
    rd(exc_pkg::ADDR_PENDING, 32'h20);
    vec_q.push_back(4'h2);
    fire(1, 6);
    drain;
    vec_q.push_back(4'h5);
    wr(exc_pkg::ADDR_MASKS, 32'h0);
    drain;
    wr(exc_pkg::ADDR_MASKS, 32'h300);
    wr(exc_pkg::ADDR_PEND_SET, 32'h20);
    repeat (10) @(posedge mclk_i);
    rd(exc_pkg::ADDR_PENDING, 32'h20);
    vec_q.push_back(4'h5);
    wr(exc_pkg::ADDR_MASKS, 32'h200);
    drain;
    wr(exc_pkg::ADDR_MASKS, 32'h2);
    wr(exc_pkg::ADDR_PEND_SET, 32'h20);
    vec_q.push_back(4'h2);
    fire(1, 6);
    drain;
    vec_q.push_back(4'h5);
    wr(exc_pkg::ADDR_MASKS, 32'h0);
    drain;
    // escalation with fault handlers disabled, under global mask
    wr(exc_pkg::ADDR_ENABLE, 32'h0);
    wr(exc_pkg::ADDR_MASKS, 32'h1);
    for (int i = 3; i < 5; i++) begin
      vec_q.push_back(4'h3);
      fire(i, 6);
      drain;
    end
    wr(exc_pkg::ADDR_MASKS, 32'h0);
    wr(exc_pkg::ADDR_PEND_SET, 32'h800);
    repeat (10) @(posedge mclk_i);
    vec_q.push_back(4'hb);
    wr(exc_pkg::ADDR_ENABLE, 32'hffffffff);
    drain;
    for (int i = 0; i < 10; i++) begin
      vec_q.push_back(src_vec[i]);
      fire(i, 6);
      drain;
    end
    vec_q.push_back(4'hf);
    fire(9, 30);
    drain;
    wr(exc_pkg::ADDR_CTRL, 32'h8000);
    free_run = 1'b1;
    fire(9, 30);
    repeat (12) @(posedge mclk_i);
    free_run = 1'b0;
    chk(n_free >= 2, "level path did not re-pend");
    for (int m = 0; m < 4; m++) begin
      power_mode_i <= 2'(m);
      repeat (4) @(posedge mclk_i);
      rd(exc_pkg::ADDR_CTRL, {14'h0, 2'(m), 16'h8000});
    end
    drain;
    // low-power entry then exit, host side order
    wr(exc_pkg::ADDR_ENABLE, 32'h0);
    wr(exc_pkg::ADDR_PEND_SET, 32'h800);
    wr(exc_pkg::ADDR_PEND_CLR, 32'hffff);
    rd(exc_pkg::ADDR_PENDING, 32'h0);
    @(posedge mclk_i);
    wr(exc_pkg::ADDR_MASKS, 32'h1);
    fire(5, 6);
    repeat (8) @(posedge mclk_i);
    rd(exc_pkg::ADDR_PENDING, 32'h800);
    vec_q.push_back(4'hb);
    wr(exc_pkg::ADDR_MASKS, 32'h0);
    repeat (8) @(posedge mclk_i);
    wr(exc_pkg::ADDR_ENABLE, 32'hffffffff);
    drain;
    test_done;
  end
endmodule
bind exception_mask_power_ctrl exc_mask_assertions chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .sys_reset_req_i(sys_reset_req_i), .ack_i(ack_i), .req_o(req_o), .vec_o(vec_o),
  .power_mode_i(power_mode_i), .power_mode_status_o(power_mode_status_o));
